// >>> logic/pcs_cfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_cfg_regs #(
  parameter int SHIFT_DIV = pcs_pkg::SHIFT_DIV
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        CFG_REQ_I,
  input  wire logic        CFG_WR_I,
  input  wire logic [5:0]  CFG_DW_I,
  input  wire logic [3:0]  CFG_BE_I,
  input  wire logic [31:0] CFG_WDATA_I,
  input  wire logic        SERIAL_IRQ_ENABLE_I,
  input  wire logic        EEPROM_PRESENT_I,
  input  wire logic        EEPROM_DATA_I,
  output logic             EEPROM_CLK_O,
  output logic             CFG_ACK_O,
  output logic             CFG_RETRY_O,
  output logic [31:0]      CFG_RDATA_O,
  output logic             IDS_LOADED_O
);
  // ===================================================
  // parameter check
  // a bit must clear the clock mirror and both synchroniser stages within one shift phase
  if (SHIFT_DIV < 4 || SHIFT_DIV > 256) begin : g_bad_div
    $error("SHIFT_DIV out of range");
  end

  // ===================================================
  // pin synchronisers
  localparam int NPIN = 2;
  logic [NPIN-1:0]      pin_raw;
  wire logic [NPIN-1:0] pin_sync;

  // bit 0 presence strap, bit 1 serial data
  assign pin_raw = {EEPROM_DATA_I, EEPROM_PRESENT_I};

  for (genvar p = 0; p < NPIN; p++) begin : g_sync
    logic s1_r, s1_nxt;
    logic s2_r, s2_nxt;

    always_comb begin
      s1_nxt = pin_raw[p];
      s2_nxt = s1_r;
    end

    // only the second stage is read outside this loop
    always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
      end else begin
        s1_r <= s1_nxt;
        s2_r <= s2_nxt;
      end
    end

    assign pin_sync[p] = s2_r;
  end

  // ===================================================
  // id load
  // presence is checked every cycle from arming until the load is done; after that a strap change needs a new reset
  logic [31:0] ids;
  logic        loaded;
  logic        sclk;

  pcs_id_loader #(.DIV(SHIFT_DIV)) u_loader (
    .clk_i     (MCLK_I),
    .rst_i     (RST_I),
    .present_i (pin_sync[0]),
    .sdata_i   (pin_sync[1]),
    .sclk_o    (sclk),
    .word_o    (ids),
    .done_o    (loaded)
  );

  // ===================================================
  // access decode
  logic        is_irq_dw;
  logic        take;
  logic        refuse;
  logic        route_wr;
  logic [15:0] vendor_code;
  logic [15:0] product_code;
  logic [7:0]  pin_val;
  logic [7:0]  route_val;
  logic [7:0]  route_r, route_nxt;

  // vendor code is shifted in first, so it lands in the upper half
  assign vendor_code  = ids[31:16];
  assign product_code = ids[15:0];

  always_comb begin
    is_irq_dw = (CFG_DW_I == pcs_pkg::DW_IRQ);
    // enable taken live, no sampling delay
    pin_val   = SERIAL_IRQ_ENABLE_I ? pcs_pkg::IRQ_PIN_NONE : pcs_pkg::IRQ_PIN_INTA;
    route_val = SERIAL_IRQ_ENABLE_I ? pcs_pkg::IRQ_ROUTING_SERIAL : route_r;
  end

  always_comb begin
    take     = 1'b0;
    refuse   = 1'b0;
    route_wr = 1'b0;
    if (CFG_REQ_I) begin
      if (!loaded) begin
        // header not trustworthy until both codes are in
        refuse = 1'b1;
      end else begin
        take = 1'b1;
        // id dword has no write path at all
        if (CFG_WR_I && is_irq_dw && CFG_BE_I[0] && !SERIAL_IRQ_ENABLE_I) begin
          route_wr = 1'b1;
        end
      end
    end
  end

  // ===================================================
  // interrupt routing register
  // a refused write never reaches this byte, so a retry leaves it intact
  always_comb begin
    route_nxt = route_r;
    if (route_wr) begin
      route_nxt = CFG_WDATA_I[7:0];
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      route_r <= pcs_pkg::IRQ_ROUTING_RST;
    end else begin
      route_r <= route_nxt;
    end
  end

  // ===================================================
  // answer strobes
  // exactly one of the two per request, standing one cycle
  logic ack_r,   ack_nxt;
  logic retry_r, retry_nxt;

  always_comb begin
    ack_nxt   = take;
    retry_nxt = refuse;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_r   <= 1'b0;
      retry_r <= 1'b0;
    end else begin
      ack_r   <= ack_nxt;
      retry_r <= retry_nxt;
    end
  end

  // ===================================================
  // read data
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    // writes, refusals and idle cycles all leave zero on the bus
    rdata_nxt = 32'h0000_0000;
    if (take && !CFG_WR_I) begin
      case (CFG_DW_I)
        pcs_pkg::DW_BOARD_IDS: rdata_nxt = {product_code, vendor_code};
        pcs_pkg::DW_IRQ:       rdata_nxt = {16'h0000, pin_val, route_val};
        default:               rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ===================================================
  // status mirrors
  // keeps every top output on a flip-flop of this module, at one cycle of lag
  logic sck_r, sck_nxt;
  logic ld_r,  ld_nxt;

  always_comb begin
    sck_nxt = sclk;
    ld_nxt  = loaded;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      sck_r <= 1'b0;
      ld_r  <= 1'b0;
    end else begin
      sck_r <= sck_nxt;
      ld_r  <= ld_nxt;
    end
  end

  // ===================================================
  // outputs
  assign EEPROM_CLK_O = sck_r;
  assign CFG_ACK_O    = ack_r;
  assign CFG_RETRY_O  = retry_r;
  assign CFG_RDATA_O  = rdata_r;
  assign IDS_LOADED_O = ld_r;
endmodule : pcs_cfg_regs
`default_nettype wire

// >>> logic/pcs_id_loader.sv
`timescale 1ns/100ps
`default_nettype none
// ===================================================
// serial id loader
module pcs_id_loader #(
  parameter int DIV = pcs_pkg::SHIFT_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        present_i,
  input  wire logic        sdata_i,
  output logic             sclk_o,
  output logic [31:0]      word_o,
  output logic             done_o
);
  // divider is eight bits; below four a bit is not yet through the pin synchroniser when sampled
  if (DIV < 4 || DIV > 256) begin : g_bad_div
    $error("DIV out of range");
  end
  logic [7:0]  div_r,  div_nxt;
  logic [1:0]  arm_r,  arm_nxt;
  logic        armed;
  logic [5:0]  cnt_r,  cnt_nxt;
  logic [31:0] sh_r,   sh_nxt;
  logic        sck_r,  sck_nxt;
  logic        done_r, done_nxt;
  logic        tick;

  assign tick   = (div_r == 8'(DIV - 1));
  // presence strap needs two synchroniser stages before it can be trusted
  assign armed  = (arm_r == 2'b11);
  assign sclk_o = sck_r;
  assign word_o = sh_r;
  assign done_o = done_r;

  always_comb begin
    div_nxt  = tick ? 8'h00 : div_r + 8'h01;
    arm_nxt  = armed ? arm_r : arm_r + 2'h1;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    sck_nxt  = sck_r;
    done_nxt = done_r;
    if (!done_r && armed) begin
      if (!present_i) begin
        // no eeprom: built-in codes, done at once
        sh_nxt   = {pcs_pkg::DEF_VENDOR_CODE, pcs_pkg::DEF_PRODUCT_CODE};
        done_nxt = 1'b1;
      end else if (tick) begin
        sck_nxt = ~sck_r;
        if (sck_r) begin
          // sample on falling shift clock edge, data settled
          sh_nxt  = {sh_r[30:0], sdata_i};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == 6'(pcs_pkg::LOAD_BITS - 1)) begin
            done_nxt = 1'b1;
          end
        end
      end
    end else begin
      sck_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r  <= 8'h00;
      arm_r  <= 2'b00;
      cnt_r  <= 6'h00;
      sh_r   <= 32'h0000_0000;
      sck_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      arm_r  <= arm_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      sck_r  <= sck_nxt;
      done_r <= done_nxt;
    end
  end
endmodule : pcs_id_loader
`default_nettype wire

// >>> logic/pcs_pkg.sv
`default_nettype none
package pcs_pkg;
  // configuration byte offsets (dword index = offset >> 2)
  localparam logic [7:0]  OFF_BOARD_VENDOR  = 8'h2c;
  localparam logic [7:0]  OFF_BOARD_PRODUCT = 8'h2e;
  localparam logic [7:0]  OFF_IRQ_ROUTING   = 8'h3c;
  localparam logic [7:0]  OFF_IRQ_PIN       = 8'h3d;
  localparam logic [5:0]  DW_BOARD_IDS      = 6'h0b;
  localparam logic [5:0]  DW_IRQ            = 6'h0f;
  // identity defaults, arbitrary values
  localparam logic [15:0] DEF_VENDOR_CODE   = 16'h5a5a;
  localparam logic [15:0] DEF_PRODUCT_CODE  = 16'h3c3c;
  localparam logic [7:0]  IRQ_ROUTING_RST   = 8'h00;
  localparam logic [7:0]  IRQ_ROUTING_SERIAL = 8'hff;
  localparam logic [7:0]  IRQ_PIN_INTA      = 8'h01;
  localparam logic [7:0]  IRQ_PIN_NONE      = 8'h00;
  // serial load: 32 data bits, vendor code first, msb first
  localparam int          LOAD_BITS         = 32;
  localparam int          SHIFT_DIV         = 4;
endpackage : pcs_pkg
`default_nettype wire

// >>> testbench/pcs_cfg_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_cfg_chk (
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic        CFG_REQ_I,
  input wire logic        CFG_WR_I,
  input wire logic [5:0]  CFG_DW_I,
  input wire logic        SERIAL_IRQ_ENABLE_I,
  input wire logic        CFG_ACK_O,
  input wire logic        CFG_RETRY_O,
  input wire logic [31:0] CFG_RDATA_O,
  input wire logic        IDS_LOADED_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  sequence s_go; CFG_REQ_I && IDS_LOADED_O; endsequence
  sequence s_irq; s_go ##0 !CFG_WR_I && CFG_DW_I == pcs_pkg::DW_IRQ; endsequence
  // loaded flag trails the internal state by one cycle
  property p_retry; CFG_REQ_I && !IDS_LOADED_O ##1 !IDS_LOADED_O |-> CFG_RETRY_O && !CFG_ACK_O; endproperty
  a_retry: assert property (p_retry) else $error("no retry");
  property p_ack; s_go |=> CFG_ACK_O && !CFG_RETRY_O; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle; !CFG_REQ_I |=> !CFG_ACK_O && !CFG_RETRY_O; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_hold; IDS_LOADED_O |=> IDS_LOADED_O; endproperty
  a_hold: assert property (p_hold) else $error("ids lost");
  property p_on; s_irq ##0 SERIAL_IRQ_ENABLE_I |=> CFG_RDATA_O == 32'h000000ff; endproperty
  a_on: assert property (p_on) else $error("irq on data");
  property p_off; s_irq ##0 !SERIAL_IRQ_ENABLE_I |=> CFG_RDATA_O[31:8] == 24'h000001; endproperty
  a_off: assert property (p_off) else $error("irq off data");
  property p_wr; CFG_REQ_I && CFG_WR_I |=> CFG_RDATA_O == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("write data");
  property p_rty; CFG_RETRY_O |-> CFG_RDATA_O == 32'h0; endproperty
  a_rty: assert property (p_rty) else $error("retry data");
endmodule : pcs_cfg_chk
bind pcs_cfg_regs pcs_cfg_chk u_chk (.MCLK_I, .RST_I, .CFG_REQ_I, .CFG_WR_I, .CFG_DW_I,
  .SERIAL_IRQ_ENABLE_I, .CFG_ACK_O, .CFG_RETRY_O, .CFG_RDATA_O, .IDS_LOADED_O);
`default_nettype wire

// >>> testbench/pcs_eeprom_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_eeprom_model #(
  parameter logic [31:0] WORD = 32'h0
) (
  input  wire logic sclk_i,
  output logic      sdata_o
);
  int n = 0;
  initial sdata_o = WORD[31];
  // new bit on rising clock, so it stands a full period; spent word toggles
  // counted on rising edges only: the unknown-to-low step at power-up is no clock
  always @(posedge sclk_i) begin
    sdata_o <= (n < 32) ? WORD[31 - n] : ~sdata_o;
    n <= n + 1;
  end
endmodule : pcs_eeprom_model
`default_nettype wire

// >>> testbench/tb_pcs_cfg_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pcs_cfg_regs;
  localparam logic [15:0] VEN = 16'h1357;
  localparam logic [15:0] PRD = 16'h2468;
  logic clk = 0, rst = 1, req = 0, wr = 0, sie = 0, pres = 1, sd, sck, ack, rty, ld;
  logic [5:0] dw = 6'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0, rd;
  int error_cnt = 0, cmp_count = 0;
  always #2 clk = ~clk;
  pcs_cfg_regs dut (.MCLK_I(clk), .RST_I(rst), .CFG_REQ_I(req), .CFG_WR_I(wr), .CFG_DW_I(dw),
    .CFG_BE_I(be), .CFG_WDATA_I(wd), .SERIAL_IRQ_ENABLE_I(sie), .EEPROM_PRESENT_I(pres),
    .EEPROM_DATA_I(sd), .EEPROM_CLK_O(sck), .CFG_ACK_O(ack), .CFG_RETRY_O(rty),
    .CFG_RDATA_O(rd), .IDS_LOADED_O(ld));
  pcs_eeprom_model #(.WORD({VEN, PRD})) eep (.sclk_i(sck), .sdata_o(sd));
  task results;
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [5:0] d, input logic [3:0] b, input logic [31:0] v,
           input logic r, input logic [31:0] e);
    @(posedge clk);
    req <= 1'b1; wr <= w; dw <= d; be <= b; wd <= v;
    @(posedge clk);
    req <= 1'b0;
    #1 chk({30'h0, rty, ack}, {30'h0, r, ~r});
    if (!w) chk(rd, e);
  endtask : acc
  task wload;
    for (int i = 0; i < 2000 && ld !== 1'b1; i++) @(posedge clk);
    if (ld !== 1'b1) begin
      error_cnt++;
      results;
    end
  endtask : wload
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    acc(0, 6'h0b, 4'hf, 32'h0, 1, 32'h0);
    acc(1, 6'h0f, 4'hf, 32'h77, 1, 32'h0);
    wload;
    chk({31'h0, sck}, 32'h0);
    acc(0, 6'h0f, 4'h0, 32'h0, 0, 32'h100);
    acc(0, 6'h0b, 4'h0, 32'h0, 0, {PRD, VEN});
    acc(1, 6'h0b, 4'hf, 32'hffffffff, 0, 32'h0);
    acc(0, 6'h0b, 4'h0, 32'h0, 0, {PRD, VEN});
    acc(1, 6'h0f, 4'hf, 32'ha5, 0, 32'h0);
    acc(1, 6'h0f, 4'he, 32'h5a, 0, 32'h0);
    acc(0, 6'h0f, 4'h0, 32'h0, 0, 32'h1a5);
    acc(0, 6'h00, 4'h0, 32'h0, 0, 32'h0);
    @(posedge clk) sie <= 1'b1;
    acc(1, 6'h0f, 4'hf, 32'h11, 0, 32'h0);
    acc(0, 6'h0f, 4'h0, 32'h0, 0, 32'hff);
    @(posedge clk) sie <= 1'b0;
    acc(0, 6'h0f, 4'h0, 32'h0, 0, 32'h1a5);
    @(posedge clk) rst <= 1'b1;
    pres <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wload;
    chk({31'h0, sck}, 32'h0);
    acc(0, 6'h0b, 4'h0, 32'h0, 0, {pcs_pkg::DEF_PRODUCT_CODE, pcs_pkg::DEF_VENDOR_CODE});
    acc(0, 6'h0f, 4'h0, 32'h0, 0, 32'h100);
    results;
  end
endmodule : tb_pcs_cfg_regs
`default_nettype wire
